//--- logic/port_arbiter_pkg.sv
// Constants and types for the repeater port arbiter
package port_arbiter_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PORT_W = 2;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned RETRY_WAIT_US = 100;
  localparam int unsigned RETRY_CYCLES = (RETRY_WAIT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned PROMOTE_US = 200;
  localparam int unsigned PROMOTE_CYCLES = (PROMOTE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W = 16;
  localparam int unsigned HEADER_OCTETS = 6;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  localparam logic [7:0] BUND_OFS = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Control fields
  localparam int unsigned CTRL_REDUNDANT = 0;
  localparam int unsigned CTRL_DIS_P = 1;
  localparam int unsigned CTRL_DIS_S = 2;
  localparam int unsigned CTRL_ACT_P = 3;
  localparam int unsigned CTRL_ACT_S = 4;
  localparam int unsigned CTRL_RETRAIN_P = 5;
  localparam int unsigned CTRL_RETRAIN_S = 6;
  typedef enum logic [2:0] {
    UL_WAIT_OTHER, UL_TRAINING, UL_ACTIVE, UL_STANDBY, UL_WAIT_TEST, UL_RETRY, UL_DISABLED
  } uplink_state_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_GRANT, ARB_RECEIVE} arb_state_t;
endpackage

//--- logic/repeater_port_arbiter.sv
// Repeater port arbiter with uplink meta-state sequencing and AHB-Lite registers
`timescale 1ns/1ps
// Function
// - Pick next port in port-number order
// - Just-served port yields to equal requests
// - High-priority requests served first, port order
// - Promotion timers raise starving normal requests
// - Grant chosen port, set its receive mode
// - Incoming to active ports except granted
// - Match destination address before frame ends
// - Overlap retransmission with reception normally
// - Bundled end-node group packets store-and-forward
// - Bundled individual packets forwarded overlapped
// - Repeater-relayed packets may forward overlapped
// - Errored frames get invalid packet markers
// - Port selection control rotates among repeaters
// - Ports independent, all initialised at power-up
// - Single uplink trains right after power-up
// - Failed single training waits then retries
// - Successful single training enters Active
// - No data on uplink while training
// - At most one redundant uplink Active, unless the secondary is activated from standby in the cycle that the primary is activated or completes training
// - Redundant uplinks no auto-retrain, have standby
// - Disable goes from any state to Disabled
// - Primary waits for secondary standby or fail
// - Secondary trains D=1 to standby, primary D=0
// - Standby with link warning goes wait-and-test
module repeater_port_arbiter
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [port_arbiter_pkg::NUM_PORTS-1:0] req_normal,
  input wire logic [port_arbiter_pkg::NUM_PORTS-1:0] req_high,
  input wire logic [port_arbiter_pkg::NUM_PORTS-1:0] port_active,
  input wire logic [port_arbiter_pkg::NUM_PORTS-1:0] port_is_repeater,
  input wire logic rx_valid,
  input wire logic [7:0] rx_octet,
  input wire logic rx_end,
  input wire logic rx_fcs_error,
  input wire logic rx_status_error,
  input wire logic rotate_in,
  input wire logic [1:0] train_done,
  input wire logic [1:0] train_fail,
  input wire logic [1:0] link_warning,
  output logic [port_arbiter_pkg::NUM_PORTS-1:0] grant,
  output logic [port_arbiter_pkg::NUM_PORTS-1:0] rx_mode,
  output logic [port_arbiter_pkg::NUM_PORTS-1:0] incoming,
  output logic [port_arbiter_pkg::NUM_PORTS-1:0] dest_match,
  output logic tx_valid,
  output logic [7:0] tx_octet,
  output logic tx_mark_invalid,
  output logic rotate_out,
  output logic [1:0] train_start,
  output logic [1:0] train_d_bit,
  output logic [1:0] uplink_data_en
);
  import port_arbiter_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire logic rst_ok = rst_sync_q;

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] addr_list_q;
  logic [NUM_PORTS-1:0] bundled_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  uplink_state_t ul_q [2];
  wire logic bus_go = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= bus_go && hwrite;
      if (bus_go)
      begin
        wr_addr_q <= haddr[7:0];
        rd_addr_q <= haddr[7:0];
      end
    end
  end

  // Action bits in control self-clear after one cycle
  always_ff @(posedge core_clk or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      ctrl_q <= CTRL_RESET;
      addr_list_q <= 32'h0000_0000;
      bundled_q <= '0;
    end
    else
    begin
      ctrl_q[CTRL_RETRAIN_S:CTRL_DIS_P] <= '0;
      if (wr_pend_q)
      begin
        unique case (wr_addr_q)
          CTRL_OFS: ctrl_q <= hwdata;
          ADDR_OFS: addr_list_q <= hwdata;
          BUND_OFS: bundled_q <= hwdata[NUM_PORTS-1:0];
          default: ;
        endcase
      end
    end
  end

  logic [PORT_W-1:0] last_q;
  arb_state_t arb_q;
  always_comb
  begin
    unique case (rd_addr_q)
      CTRL_OFS: hrdata = ctrl_q;
      STAT_OFS: hrdata = {20'h0_0000, 1'b0, ul_q[1], 1'b0, ul_q[0], arb_q, last_q};
      ADDR_OFS: hrdata = addr_list_q;
      BUND_OFS: hrdata = {28'h000_0000, bundled_q};
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Promotion timers
  // ****************************************
  logic [CNT_W-1:0] wait_cnt_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] promoted;
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_prom
      always_ff @(posedge core_clk or negedge rst_ok)
      begin
        if (!rst_ok)
          wait_cnt_q[g] <= '0;
        else if (!req_normal[g] || grant[g])
          wait_cnt_q[g] <= '0;
        else if (!promoted[g])
          wait_cnt_q[g] <= wait_cnt_q[g] + 1'b1;
      end
      assign promoted[g] = (wait_cnt_q[g] >= CNT_W'(PROMOTE_CYCLES));
    end
  endgenerate

  // ****************************************
  // Round-robin selection
  // ****************************************
  wire logic [NUM_PORTS-1:0] eff_high = (req_high | (req_normal & promoted)) & port_active;
  wire logic [NUM_PORTS-1:0] eff_norm = req_normal & port_active;
  wire logic [NUM_PORTS-1:0] cand = (eff_high != '0) ? eff_high : eff_norm;
  logic pick_ok;
  logic [PORT_W-1:0] pick;
  always_comb
  begin
    logic [PORT_W-1:0] idx;
    idx = '0;
    pick_ok = 1'b0;
    pick = '0;
    // Scan starts after last served port so it comes up last
    for (int i = 1; i <= NUM_PORTS; i++)
    begin
      idx = PORT_W'(int'(last_q) + i);
      if (!pick_ok && cand[idx])
      begin
        pick_ok = 1'b1;
        pick = idx;
      end
    end
  end

  // ****************************************
  // Grant and receive sequencing
  // ****************************************
  logic [PORT_W-1:0] sel_q;
  logic [3:0] oct_cnt_q;
  logic group_q;
  logic hold_q;
  logic err_q;
  logic [7:0] buf_q [2**12];
  logic [11:0] wptr_q;
  logic [11:0] rptr_q;
  logic draining_q;
  wire logic sf_cond = bundled_q[sel_q] && !port_is_repeater[sel_q];

  always_ff @(posedge core_clk or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      arb_q <= ARB_IDLE;
      sel_q <= '0;
      last_q <= PORT_W'(NUM_PORTS - 1);
      rotate_out <= 1'b0;
    end
    else
    begin
      rotate_out <= 1'b0;
      unique case (arb_q)
        ARB_IDLE:
          if (pick_ok && rotate_in && !draining_q)
          begin
            sel_q <= pick;
            arb_q <= ARB_GRANT;
          end
        ARB_GRANT:
          arb_q <= ARB_RECEIVE;
        ARB_RECEIVE:
          if (rx_valid && rx_end)
          begin
            last_q <= sel_q;
            rotate_out <= (sel_q == PORT_W'(NUM_PORTS - 1));
            arb_q <= ARB_IDLE;
          end
      endcase
    end
  end

  always_comb
  begin
    grant = '0;
    rx_mode = '0;
    incoming = '0;
    if (arb_q != ARB_IDLE)
    begin
      grant[sel_q] = 1'b1;
      rx_mode[sel_q] = 1'b1;
    end
    if (arb_q == ARB_RECEIVE)
    begin
      incoming = port_active;
      incoming[sel_q] = 1'b0;
    end
  end

  // Header decode; first octet LSB marks group address
  always_ff @(posedge core_clk or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      oct_cnt_q <= '0;
      group_q <= 1'b0;
      hold_q <= 1'b0;
      err_q <= 1'b0;
      dest_match <= '0;
    end
    else if (arb_q == ARB_GRANT)
    begin
      oct_cnt_q <= '0;
      err_q <= 1'b0;
      hold_q <= 1'b0;
      dest_match <= '0;
    end
    else if (arb_q == ARB_RECEIVE && rx_valid)
    begin
      if (oct_cnt_q != 4'(HEADER_OCTETS))
        oct_cnt_q <= oct_cnt_q + 1'b1;
      if (oct_cnt_q == 4'd0)
      begin
        group_q <= rx_octet[0];
        hold_q <= rx_octet[0] && sf_cond;
        // Per-port address byte matched on first octet
        for (int p = 0; p < NUM_PORTS; p++)
          dest_match[p] <= rx_octet[0] || (addr_list_q[8*p +: 8] == rx_octet);
      end
      if (rx_fcs_error || rx_status_error)
        err_q <= 1'b1;
    end
  end

  // ****************************************
  // Forwarding buffer: overlapped or store-and-forward
  // ****************************************
  wire logic wr_en = (arb_q == ARB_RECEIVE) && rx_valid;
  wire logic frame_end = wr_en && rx_end;
  logic [11:0] end_ptr_q;
  logic mark_q;
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      buf_q[wptr_q] <= rx_octet;
  end
  always_ff @(posedge core_clk or negedge rst_ok)
  begin
    if (!rst_ok)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      end_ptr_q <= '0;
      draining_q <= 1'b0;
      mark_q <= 1'b0;
      tx_valid <= 1'b0;
      tx_octet <= 8'h00;
      tx_mark_invalid <= 1'b0;
    end
    else
    begin
      tx_valid <= 1'b0;
      tx_mark_invalid <= 1'b0;
      if (wr_en)
        wptr_q <= wptr_q + 1'b1;
      if (frame_end)
      begin
        draining_q <= 1'b1;
        end_ptr_q <= wptr_q + 1'b1;
        mark_q <= err_q || rx_fcs_error || rx_status_error;
      end
      // Overlapped unless held; held frames drain after end
      if (rptr_q != wptr_q && (!hold_q || draining_q))
      begin
        tx_valid <= 1'b1;
        tx_octet <= buf_q[rptr_q];
        rptr_q <= rptr_q + 1'b1;
      end
      else if (draining_q && rptr_q == end_ptr_q && !frame_end)
      begin
        draining_q <= 1'b0;
        tx_mark_invalid <= mark_q;
      end
    end
  end

  // ****************************************
  // Uplink meta-states
  // ****************************************
  logic [CNT_W-1:0] retry_cnt_q [2];
  wire logic redundant = ctrl_q[CTRL_REDUNDANT];
  generate
    for (g = 0; g < 2; g++)
    begin : g_ul
      wire logic dis = ctrl_q[CTRL_DIS_P + g];
      wire logic act = ctrl_q[CTRL_ACT_P + g];
      wire logic retrain = ctrl_q[CTRL_RETRAIN_P + g];
      wire logic other_act = (ul_q[1-g] == UL_ACTIVE);
      wire logic other_busy = (ul_q[1-g] == UL_TRAINING) || (ul_q[1-g] == UL_WAIT_OTHER);
      always_ff @(posedge core_clk or negedge rst_ok)
      begin
        if (!rst_ok)
        begin
          ul_q[g] <= UL_WAIT_OTHER;
          retry_cnt_q[g] <= '0;
        end
        else if (dis)
          ul_q[g] <= UL_DISABLED;
        else
        begin
          unique case (ul_q[g])
            UL_WAIT_OTHER:
              // Primary is index 0; secondary or single starts at once
              if (g == 1 || !redundant || !other_busy)
                ul_q[g] <= UL_TRAINING;
            UL_TRAINING:
              if (train_fail[g])
              begin
                retry_cnt_q[g] <= '0;
                ul_q[g] <= redundant ? UL_WAIT_TEST : UL_RETRY;
              end
              else if (train_done[g])
                ul_q[g] <= (redundant && (g == 1 || other_act)) ? UL_STANDBY
                         : UL_ACTIVE;
            UL_RETRY:
              if (retry_cnt_q[g] == CNT_W'(RETRY_CYCLES - 1))
                ul_q[g] <= UL_TRAINING;
              else
                retry_cnt_q[g] <= retry_cnt_q[g] + 1'b1;
            UL_ACTIVE:
              if (train_fail[g] || link_warning[g])
                ul_q[g] <= redundant ? UL_WAIT_TEST : UL_RETRY;
            UL_STANDBY:
              if (link_warning[g])
                ul_q[g] <= UL_WAIT_TEST;
              else if ((act || ul_q[1-g] == UL_WAIT_TEST) && !other_act && g == 0 | act)
                ul_q[g] <= UL_ACTIVE;
            UL_WAIT_TEST, UL_DISABLED:
              if (retrain || act)
                ul_q[g] <= UL_TRAINING;
          endcase
        end
      end
      assign train_start[g] = (ul_q[g] == UL_TRAINING);
      assign train_d_bit[g] = redundant && (g == 1);
      assign uplink_data_en[g] = (ul_q[g] == UL_ACTIVE);
    end
  endgenerate
endmodule

//--- test/repeater_port_arbiter_sva.sv
// Concurrent checks on the port arbiter outputs
`timescale 1ns/1ps
module repeater_port_arbiter_sva
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] grant,
  input wire logic [3:0] rx_mode,
  input wire logic [3:0] incoming,
  input wire logic [3:0] req_high,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic [1:0] train_start,
  input wire logic [1:0] train_d_bit,
  input wire logic [1:0] uplink_data_en
);
  // ***
  // Properties
  // ***
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence grant_rise;
    $rose(|grant);
  endsequence
  sequence mid_frame;
    (|grant) && rx_valid && !rx_end;
  endsequence
  chk_grant_onehot: assert property ($onehot0(grant))
    else $error("more than one port granted");
  chk_rx_mode_pair: assert property (rx_mode == grant)
    else $error("receive mode differs from grant");
  chk_incoming_excl: assert property ((incoming & grant) == 4'h0)
    else $error("incoming sent to granted port");
  chk_high_first: assert property (grant_rise |->
    $past(req_high) == 4'h0 || (grant & $past(req_high)) != 4'h0)
    else $error("normal port granted over high request");
  chk_grant_hold: assert property (mid_frame |=> $stable(grant))
    else $error("grant moved inside a frame");
  // Secondary D bit marks redundant mode; single mode may run both uplinks
  chk_one_uplink: assert property (train_d_bit[1] |-> uplink_data_en != 2'b11)
    else $error("both uplinks carry data");
  chk_train_quiet: assert property ((train_start & uplink_data_en) == 2'b00)
    else $error("data enabled on a training uplink");
  chk_primary_dbit: assert property (!train_d_bit[0])
    else $error("primary uplink trains with D bit set");
endmodule
bind repeater_port_arbiter repeater_port_arbiter_sva u_sva (.core_clk, .rst_n, .grant,
  .rx_mode, .incoming, .req_high, .rx_valid, .rx_end, .train_start, .train_d_bit,
  .uplink_data_en);

//--- test/uplink_partner_model.sv
// Higher-level repeater that answers uplink training
`timescale 1ns/1ps
module uplink_partner_model
#(
  parameter int ANSWER_CYCLES = 8
)
(
  input wire logic core_clk,
  input wire logic [1:0] train_start,
  input wire logic [1:0] fail_en,
  output logic [1:0] train_done = 2'h0,
  output logic [1:0] train_fail = 2'h0
);
  // ***
  // Training answer
  // ***
  int cnt [2] = '{0, 0};
  always @(posedge core_clk)
  begin
    for (int u = 0; u < 2; u++)
    begin
      cnt[u] <= train_start[u] ? cnt[u] + 1 : 0;
      train_done[u] <= train_start[u] && cnt[u] == ANSWER_CYCLES && !fail_en[u];
      train_fail[u] <= train_start[u] && cnt[u] == ANSWER_CYCLES && fail_en[u];
    end
  end
endmodule

//--- test/repeater_port_arbiter_tb.sv
// Self-checking testbench for the repeater port arbiter
`timescale 1ns/1ps
module repeater_port_arbiter_tb;
  import port_arbiter_pkg::*;
  // ***
  // Signals and instances
  // ***
  logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rx_valid = 0, rx_end = 0;
  logic rx_fcs_error = 0, hreadyout, hresp, tx_valid, tx_mark_invalid, rotate_out;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, fail_en = 2'h1, train_done, train_fail;
  logic [1:0] train_start, train_d_bit, uplink_data_en;
  logic [2:0] hsize = 3'h2;
  logic [7:0] rx_octet = 8'h0, tx_octet;
  logic [3:0] req_normal = 4'h0, req_high = 4'h0, port_active = 4'hf, port_is_repeater = 4'h0;
  logic [3:0] grant, rx_mode, incoming, dest_match;
  int fails = 0, comparisons = 0;
  always #25 core_clk = ~core_clk;
  repeater_port_arbiter u_dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req_normal, .req_high,
    .port_active, .port_is_repeater, .rx_valid, .rx_octet, .rx_end, .rx_fcs_error,
    .rx_status_error(1'b0), .rotate_in(1'b1), .train_done, .train_fail,
    .link_warning(2'h0), .grant, .rx_mode, .incoming, .dest_match, .tx_valid, .tx_octet,
    .tx_mark_invalid, .rotate_out, .train_start, .train_d_bit, .uplink_data_en);
  uplink_partner_model u_partner (.core_clk, .train_start, .fail_en, .train_done,
    .train_fail);
  // ***
  // Shared tasks
  // ***
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return train_start[0];
      1: return !train_start[0];
      2: return uplink_data_en[0];
      3: return !uplink_data_en[0];
      default: return grant[w - 4];
    endcase
  endfunction
  task automatic wait_for(input int w, input int lim, input string what);
    int i;
    i = 0;
    while (sig(w) !== 1'b1 && i < lim)
    begin
      @(posedge core_clk);
      i++;
    end
    chk(what, 32'h1, {31'h0, sig(w)});
  endtask
  function automatic int nxt(input int p, input logic [3:0] m);
    for (int i = 1; i <= 4; i++)
      if (m[(p + i) % 4]) return (p + i) % 4;
    return p;
  endfunction
  // Six-octet frame from port p; requests change with the last octet
  task automatic frame(input int p, input logic [7:0] b0, input logic err,
    input logic [7:0] nreq, output logic early, output logic mark);
    early = 1'b0;
    mark = 1'b0;
    wait_for(p + 4, 40, "grant");
    @(posedge core_clk);
    chk("incoming", {28'h0, port_active & ~grant}, {28'h0, incoming});
    for (int k = 0; k < 6; k++)
    begin
      rx_valid <= 1'b1;
      rx_octet <= (k == 0) ? b0 : 8'(k);
      rx_end <= (k == 5);
      rx_fcs_error <= err && (k == 5);
      if (k == 5)
        {req_high, req_normal} <= nreq;
      @(posedge core_clk);
      early |= (tx_valid === 1'b1) && (k < 5);
    end
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    rx_fcs_error <= 1'b0;
    repeat (20)
    begin
      @(posedge core_clk);
      mark |= (tx_mark_invalid === 1'b1);
    end
  endtask
  // ***
  // Scenarios
  // ***
  task automatic s_uplink;
    logic [31:0] rd;
    wait_for(0, 10, "uplink trains");
    wait_for(1, 40, "training failed");
    fail_en <= 2'h0;
    wait_for(0, 2500, "retry begins");
    wait_for(2, 40, "uplink active");
    ahb(1'b1, CTRL_OFS, 32'h1 << CTRL_DIS_P, rd);
    wait_for(3, 10, "uplink disabled");
  endtask
  task automatic s_registers;
    logic [31:0] rd;
    ahb(1'b0, CTRL_OFS, 32'h0, rd);
    chk("ctrl", CTRL_RESET, rd);
    ahb(1'b1, BUND_OFS, 32'h2, rd);
    ahb(1'b0, BUND_OFS, 32'h0, rd);
    chk("bundled", 32'h2, {28'h0, rd[3:0]});
    ahb(1'b1, 8'h10, 32'hffff_ffff, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic s_round_robin;
    int p;
    logic e, m;
    port_active <= 4'hb;
    req_normal <= 4'hf;
    repeat (3) @(posedge core_clk);
    p = 0;
    for (int q = 3; q >= 0; q--)
      if (grant[q] === 1'b1) p = q;
    for (int n = 0; n < 4; n++)
    begin
      frame(p, 8'h02, 1'b0, (n == 3) ? 8'h00 : 8'h0f, e, m);
      p = nxt(p, 4'hb);
    end
  endtask
  task automatic s_high;
    logic e, m;
    port_active <= 4'hf;
    {req_high, req_normal} <= 8'h43;
    frame(2, 8'h02, 1'b0, 8'h03, e, m);
    chk("clean mark", 32'h0, {31'h0, m});
    frame(0, 8'h02, 1'b1, 8'h00, e, m);
    chk("error mark", 32'h1, {31'h0, m});
  endtask
  task automatic s_store;
    logic e, m;
    logic [7:0] b0 [3] = '{8'h01, 8'h02, 8'h01};
    logic [3:0] rep [3] = '{4'h0, 4'h0, 4'h2};
    logic ex [3] = '{1'b0, 1'b1, 1'b1};
    for (int n = 0; n < 3; n++)
    begin
      port_is_repeater <= rep[n];
      req_normal <= 4'h2;
      frame(1, b0[n], 1'b0, 8'h00, e, m);
      chk("overlap", {31'h0, ex[n]}, {31'h0, e});
    end
  endtask
  // Redundant mode: primary activated while secondary is active must stand by
  task automatic s_redundant;
    logic [31:0] rd;
    ahb(1'b1, CTRL_OFS, (32'h1 << CTRL_REDUNDANT) | (32'h1 << CTRL_ACT_P), rd);
    repeat (30) @(posedge core_clk);
    ahb(1'b0, STAT_OFS, 32'h0, rd);
    chk("primary state", {29'h0, UL_STANDBY}, {29'h0, rd[6:4]});
    chk("uplink data", 32'h2, {30'h0, uplink_data_en});
    chk("d bits", 32'h2, {30'h0, train_d_bit});
  endtask
  initial
  begin
    repeat (10000) @(posedge core_clk);
    fails++;
    tally_and_finish();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    s_uplink();
    s_registers();
    s_round_robin();
    s_high();
    s_store();
    s_redundant();
    tally_and_finish();
  end
endmodule
